/* pkg/chrg_map.vh */
// Constants of the charger control, status and wake logic
`ifndef CHRG_MAP_VH
`define CHRG_MAP_VH

// ********************************************
// Clock and timing
// ********************************************
`define CHRG_CLK_KHZ      25000
`define CHRG_TERM_MS      25
`define CHRG_RECHG_MS     100
`define CHRG_PLUG_MS      19
`define CHRG_WAKE_MS      90
`define CHRG_TERM_CYC     (`CHRG_TERM_MS * `CHRG_CLK_KHZ)
`define CHRG_RECHG_CYC    (`CHRG_RECHG_MS * `CHRG_CLK_KHZ)
`define CHRG_PLUG_CYC     (`CHRG_PLUG_MS * `CHRG_CLK_KHZ)
`define CHRG_WAKE_CYC     (`CHRG_WAKE_MS * `CHRG_CLK_KHZ)
`define CHRG_CNT_W        22

// ********************************************
// Charge phase states, one-hot
// ********************************************
`define CHRG_ST_OFF       4'h1
`define CHRG_ST_PRE       4'h2
`define CHRG_ST_FAST      4'h4
`define CHRG_ST_DONE      4'h8

// ********************************************
// Field widths, zone code and reset values
// ********************************************
`define CHRG_ZONE_W       3
`define CHRG_ZONE_EVENT   3'h0
`define CHRG_CODE_W       4
`define CHRG_FLAGS_W      7
`define CHRG_FLAGS_RST    7'h00

`endif

/* rtl/chrg_status_irq_wake.v */
// Charger phase sequencer, status flags, interrupt line and wake pulse
`timescale 1ns/1ps
`include "chrg_map.vh"

// ********************************************
// Deglitch timer: pulses once after COUNT uninterrupted cycles
// ********************************************
module chrg_dglitch #(
    parameter COUNT = 4,
    parameter W     = 22
) (
    // Clock and reset
    input  wire       mclk_i,
    input  wire       rstn_i,
    // Condition and result
    input  wire       cond_i,
    output wire       fire_o
);
    reg  [W-1:0] cnt_r;                 // Cycles the condition has held
    wire         last;                  // Final cycle of the interval

    assign last   = (cnt_r == COUNT - 1);
    assign fire_o = cond_i && last;

    // Count while held, restart from zero on any drop, saturate at COUNT
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            cnt_r <= {W{1'b0}};
        end else if (!cond_i) begin
            cnt_r <= {W{1'b0}};        // see R19
        end else if (cnt_r != COUNT) begin
            cnt_r <= cnt_r + 1'b1;
        end
    end
endmodule // chrg_dglitch

//Summary of operation
//R1: Below 2.8V charge in reduced pre-charge
//R2: Above 3V request full programmed current
//R3: CV under termination 25ms ends charging
//R4: Below 4.1V for 100ms restarts charging
//R5: Interrupt pin open-drain, low while pending
//R6: Any status flag change sets pending
//R7: Host writes 0 or power-on clears pending
//R8: At turn-on assert only if flag set
//R9: Both edges count; running only falling
//R10: Thermistor zone 000 is an event
//R11: Droop mask blocks droop interrupts
//R12: Thermistor above 90% bias flags absent battery
//R13: Power good only inside offset/overvoltage window
//R14: Done flag after termination, sets pending
//R15: 19ms plug-in gives one 90ms wake
//R16: Enable high blocks new wake pulses
//R17: Running wake pulse always completes fully
//R18: Suspend stops charging, indicator high impedance
//R19: Deglitch timers restart when condition drops
//R20: Writing 1 ignored; event beats clear
module chrg_status_irq_wake #(
    parameter TERM_CYC  = `CHRG_TERM_CYC,
    parameter RECHG_CYC = `CHRG_RECHG_CYC,
    parameter PLUG_CYC  = `CHRG_PLUG_CYC,
    parameter WAKE_CYC  = `CHRG_WAKE_CYC
) (
    // Clock and reset
    input  wire                     mclk_i,
    input  wire                     rstn_i,
    // Power unit and host controls
    input  wire                     pmu_on_i,
    input  wire                     suspend_request_i,
    input  wire [`CHRG_CODE_W-1:0]  fast_current_code_i,
    input  wire                     droop_irq_mask_i,
    input  wire                     irq_wr_i,
    input  wire                     irq_wdata_i,
    input  wire                     ext_enable_i,
    // Battery comparators
    input  wire                     vbat_below_2v8_i,
    input  wire                     vbat_above_3v_i,
    input  wire                     cv_near_4v2_i,
    input  wire                     ichg_below_term_i,
    input  wire                     vbat_below_4v1_i,
    // Input supply comparators
    input  wire                     vin_above_uvlo_i,
    input  wire                     vin_above_bat_osl_i,
    input  wire                     vin_above_bat_osh_i,
    input  wire                     vin_above_ovp_i,
    // Thermistor and other status sources
    input  wire                     ts_above_90pct_i,
    input  wire [`CHRG_ZONE_W-1:0]  thermistor_zone_i,
    input  wire                     thermal_regulation_flag_i,
    input  wire                     safety_timer_flag_i,
    input  wire                     input_droop_flag_i,
    // Plug-in detectors
    input  wire                     plug_bat_i,
    input  wire                     plug_vin_i,
    // Charge request outputs
    output reg                      charge_enable_o,
    output reg                      precharge_o,
    output reg  [`CHRG_CODE_W-1:0]  charge_code_o,
    // Status flags
    output reg                      input_power_ok_o,
    output reg                      battery_absent_o,
    output reg                      charge_done_o,
    output reg                      charge_running_o,
    output reg                      irq_pending_flag_o,
    // Open-drain pins and wake
    output wire                     irq_line_o,
    output wire                     irq_line_oe_o,
    output wire                     charge_indicator_pin_o,
    output wire                     charge_indicator_pin_oe_o,
    output reg                      wake_o
);

    // ********************************************
    // Declarations
    // ********************************************
    reg  [3:0]                   state_r;       // Charge phase
    reg  [3:0]                   state_nxt;     // Next charge phase
    reg                          done_r;        // Termination seen
    reg                          done_nxt;      // Next termination flag
    reg                          pmu_on_r;      // Power unit state last cycle
    reg  [`CHRG_FLAGS_W-1:0]     flags_r;       // Flags last cycle
    reg  [`CHRG_ZONE_W-1:0]      zone_r;        // Zone last cycle
    reg                          running_r;     // Running flag last cycle
    reg                          input_power_ok_nxt;     // Next power good value
    reg                          wake_busy_r;   // Wake pulse in flight
    reg  [`CHRG_CNT_W-1:0]       wake_cnt_r;    // Wake pulse width counter
    wire [`CHRG_FLAGS_W-1:0]     flags_now;     // Edge-sensitive flags
    wire                         turn_on;       // Power unit rising edge
    wire                         charge_ok;     // Power good, no suspend, battery present
    wire                         term_fire;     // Termination deglitched
    wire                         rechg_fire;    // Recharge deglitched
    wire                         plug_fire;     // Plug-in deglitched
    wire                         droop_evt;     // Droop change, unmasked
    wire                         flag_evt;      // Flag change during on
    wire                         on_evt;        // Flag present at turn-on
    wire                         run_fall;      // Running flag fell
    wire                         irq_set;       // Any interrupt event
    wire                         irq_clr;       // Clearing write or power-on

    // ********************************************
    // Deglitch timers
    // ********************************************
    // Constant-voltage phase with current under termination level
    chrg_dglitch #(
        .COUNT (TERM_CYC),
        .W     (`CHRG_CNT_W)
    ) u_term (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .cond_i (state_r == `CHRG_ST_FAST && cv_near_4v2_i && ichg_below_term_i),
        .fire_o (term_fire)
    );

    // Battery sagging below recharge level after termination
    chrg_dglitch #(
        .COUNT (RECHG_CYC),
        .W     (`CHRG_CNT_W)
    ) u_rechg (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .cond_i (state_r == `CHRG_ST_DONE && vbat_below_4v1_i),
        .fire_o (rechg_fire)
    );

    // Battery or supply plug-in held long enough
    chrg_dglitch #(
        .COUNT (PLUG_CYC),
        .W     (`CHRG_CNT_W)
    ) u_plug (
        .mclk_i (mclk_i),
        .rstn_i (rstn_i),
        .cond_i (plug_bat_i || plug_vin_i),
        .fire_o (plug_fire)
    );

    // ********************************************
    // Charge phase sequencer
    // ********************************************
    assign charge_ok = input_power_ok_o && !suspend_request_i && !battery_absent_o;

    // Next phase from the raw 2.8V and 3V comparators and the deglitch timer pulses
    always @* begin
        state_nxt = state_r;
        done_nxt  = done_r;
        if (!charge_ok) begin
            state_nxt = `CHRG_ST_OFF;                  // see R18
            done_nxt  = 1'b0;
        end else begin
            case (state_r)
                `CHRG_ST_OFF: begin
                    // Between 2.8V and 3V start gently
                    if (vbat_above_3v_i) begin
                        state_nxt = `CHRG_ST_FAST;     // see R2
                    end else begin
                        state_nxt = `CHRG_ST_PRE;      // see R1
                    end
                end
                `CHRG_ST_PRE: begin
                    if (vbat_above_3v_i) begin
                        state_nxt = `CHRG_ST_FAST;     // see R2
                    end
                end
                `CHRG_ST_FAST: begin
                    if (term_fire) begin
                        state_nxt = `CHRG_ST_DONE;     // see R3
                        done_nxt  = 1'b1;              // see R14
                    end else if (vbat_below_2v8_i) begin
                        state_nxt = `CHRG_ST_PRE;      // see R1
                    end
                end
                `CHRG_ST_DONE: begin
                    // Recharge keeps the done flag up
                    if (rechg_fire) begin
                        state_nxt = `CHRG_ST_FAST;     // see R4
                    end
                end
                default: begin
                    state_nxt = `CHRG_ST_OFF;
                end
            endcase
        end
    end

    // Phase register and charge request outputs
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r          <= `CHRG_ST_OFF;
            done_r           <= 1'b0;
            charge_enable_o  <= 1'b0;
            precharge_o      <= 1'b0;
            charge_code_o    <= {`CHRG_CODE_W{1'b0}};
            charge_done_o    <= 1'b0;
            charge_running_o <= 1'b0;
        end else begin
            state_r          <= state_nxt;
            done_r           <= done_nxt;
            charge_enable_o  <= (state_nxt == `CHRG_ST_PRE) ||
                                (state_nxt == `CHRG_ST_FAST);   // see R3
            precharge_o      <= (state_nxt == `CHRG_ST_PRE);    // see R1
            charge_code_o    <= fast_current_code_i;            // see R2
            charge_done_o    <= done_nxt;                       // see R14
            charge_running_o <= (state_nxt == `CHRG_ST_PRE) ||
                                (state_nxt == `CHRG_ST_FAST);
        end
    end

    // Indicator pulled low only while charging before termination
    assign charge_indicator_pin_o    = 1'b0;
    assign charge_indicator_pin_oe_o = charge_running_o && !charge_done_o; // see R3 R18

    // ********************************************
    // Status flags
    // ********************************************
    // Power good window with hysteresis between the offsets
    always @* begin
        input_power_ok_nxt = input_power_ok_o;
        if (!vin_above_uvlo_i || vin_above_ovp_i || !vin_above_bat_osl_i) begin
            input_power_ok_nxt = 1'b0;                          // see R13
        end else if (vin_above_bat_osh_i) begin
            input_power_ok_nxt = 1'b1;                          // see R13
        end
    end

    // Flag registers
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            input_power_ok_o <= 1'b0;
            battery_absent_o <= 1'b0;
        end else begin
            input_power_ok_o <= input_power_ok_nxt;
            battery_absent_o <= pmu_on_i && ts_above_90pct_i;    // see R12
        end
    end

    // ********************************************
    // Interrupt pending flag
    // ********************************************
    // Flags that count on both edges; zone handled on its own
    assign flags_now = {input_power_ok_o, battery_absent_o,
                        (thermistor_zone_i == `CHRG_ZONE_EVENT),
                        charge_done_o, thermal_regulation_flag_i,
                        safety_timer_flag_i, input_droop_flag_i};
    assign turn_on   = pmu_on_i && !pmu_on_r;

    // Droop changes only when unmasked
    assign droop_evt = (flags_now[0] != flags_r[0]) && !droop_irq_mask_i;    // see R11
    assign flag_evt  = pmu_on_r && pmu_on_i &&
                       ((flags_now[6:1] != flags_r[6:1]) || droop_evt ||
                        (thermistor_zone_i != zone_r));             // see R6 R9 R10
    assign run_fall  = pmu_on_r && pmu_on_i && running_r && !charge_running_o; // see R9
    assign on_evt    = turn_on && ((|flags_now[6:1]) ||
                       (flags_now[0] && !droop_irq_mask_i));        // see R8 R10 R11
    assign irq_set   = flag_evt || run_fall || on_evt;
    assign irq_clr   = (irq_wr_i && !irq_wdata_i) || turn_on;       // see R7 R20

    // History registers and the sticky flag; set beats clear
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pmu_on_r           <= 1'b0;
            flags_r            <= `CHRG_FLAGS_RST;
            zone_r             <= {`CHRG_ZONE_W{1'b0}};
            running_r          <= 1'b0;
            irq_pending_flag_o <= 1'b0;
        end else begin
            pmu_on_r  <= pmu_on_i;
            flags_r   <= flags_now;
            zone_r    <= thermistor_zone_i;
            running_r <= charge_running_o;
            if (irq_set) begin
                irq_pending_flag_o <= 1'b1;            // see R6 R12 R14 R20
            end else if (irq_clr) begin
                irq_pending_flag_o <= 1'b0;            // see R7
            end
        end
    end

    // Open-drain line pulled low while pending
    assign irq_line_o    = 1'b0;
    assign irq_line_oe_o = irq_pending_flag_o;        // see R5

    // ********************************************
    // Wake pulse generator
    // ********************************************
    // Start only when idle and enable low; run to full width once started
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_busy_r <= 1'b0;
            wake_cnt_r  <= {`CHRG_CNT_W{1'b0}};
            wake_o      <= 1'b0;
        end else if (wake_busy_r) begin
            if (wake_cnt_r == WAKE_CYC - 1) begin
                wake_busy_r <= 1'b0;                  // see R17
                wake_o      <= 1'b0;
                wake_cnt_r  <= {`CHRG_CNT_W{1'b0}};
            end else begin
                wake_cnt_r  <= wake_cnt_r + 1'b1;
            end
        end else if (plug_fire && !ext_enable_i) begin
            wake_busy_r <= 1'b1;                      // see R15 R16
            wake_o      <= 1'b1;
            wake_cnt_r  <= {`CHRG_CNT_W{1'b0}};
        end
    end

endmodule // chrg_status_irq_wake

/* dv/chrg_status_irq_wake_chk.sv */
// Assertion checker bound to the charger status, interrupt and wake block
`timescale 1ns/1ps
module chrg_swk_chk #(
    parameter TERM_CYC = 4,
    parameter WAKE_CYC = 4
) (
    // Clock, reset, inputs and the charge code output
    input wire       mclk_i, rstn_i, pmu_on_i, suspend_request_i, irq_wr_i, irq_wdata_i,
    input wire       ext_enable_i, vbat_below_2v8_i, vbat_above_3v_i, cv_near_4v2_i,
    input wire       ichg_below_term_i, vin_above_uvlo_i, vin_above_bat_osl_i,
    input wire       vin_above_bat_osh_i, vin_above_ovp_i, ts_above_90pct_i,
    input wire [3:0] fast_current_code_i, charge_code_o,
    // Outputs under watch
    input wire       charge_enable_o, precharge_o, input_power_ok_o, battery_absent_o,
    input wire       charge_done_o, charge_running_o, irq_pending_flag_o, irq_line_o, irq_line_oe_o,
    input wire       charge_indicator_pin_o, charge_indicator_pin_oe_o, wake_o
);
    reg [23:0] wake_cnt_r;  // Cycles the wake pulse has been high
    reg [23:0] term_cnt_r;  // Cycles of unbroken termination condition
    // Helper counters for the timed relations
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wake_cnt_r <= 24'h000000;
            term_cnt_r <= 24'h000000;
        end else begin
            wake_cnt_r <= wake_o ? wake_cnt_r + 24'h000001 : 24'h000000;
            term_cnt_r <= (cv_near_4v2_i && ichg_below_term_i) ?
                          term_cnt_r + 24'h000001 : 24'h000000;
        end
    end
    default clocking dflt_cb @(posedge mclk_i);
    endclocking
    default disable iff (!rstn_i);
    AST_IRQ_PIN: assert property (irq_line_oe_o == irq_pending_flag_o && !irq_line_o)
        else $error("Interrupt pin differs from pending bit");
    AST_IRQ_HOLD: assert property (irq_pending_flag_o && pmu_on_i && $past(pmu_on_i) &&
        !(irq_wr_i && !irq_wdata_i) |=> irq_pending_flag_o) else $error("Pending bit lost");
    AST_BAT_ABS: assert property (1'b1 |=>
        battery_absent_o == $past(pmu_on_i && ts_above_90pct_i)) else $error("Absent flag wrong");
    AST_INPUT_POWER_OK_HI: assert property (vin_above_uvlo_i && vin_above_bat_osh_i &&
        !vin_above_ovp_i |=> input_power_ok_o) else $error("Power good missing");
    AST_INPUT_POWER_OK_LO: assert property (!vin_above_uvlo_i || !vin_above_bat_osl_i ||
        vin_above_ovp_i |=> !input_power_ok_o) else $error("Power good outside window");
    AST_DONE_IRQ: assert property ($rose(charge_done_o) && pmu_on_i && $past(pmu_on_i)
        ##1 pmu_on_i |-> ##[0:1] irq_pending_flag_o) else $error("Done gave no interrupt");
    AST_DONE_STOP: assert property ($rose(charge_done_o) |->
        !charge_enable_o && term_cnt_r >= TERM_CYC) else $error("Early or running termination");
    AST_IND_REL: assert property (charge_done_o |->
        !charge_indicator_pin_oe_o && !charge_indicator_pin_o) else $error("Indicator driven");
    AST_SUSPEND: assert property (suspend_request_i [*3] |->
        !charge_enable_o && !charge_indicator_pin_oe_o) else $error("Charging in suspend");
    AST_FAST: assert property ((vbat_above_3v_i && !vbat_below_2v8_i) [*3] |->
        !precharge_o) else $error("Reduced current above threshold");
    AST_CODE: assert property (1'b1 |=>
        charge_code_o == $past(fast_current_code_i)) else $error("Current code not passed");
    AST_WAKE_LEN: assert property ($fell(wake_o) |-> wake_cnt_r == WAKE_CYC)
        else $error("Wake width wrong");
    AST_WAKE_EN: assert property ($rose(wake_o) |-> !$past(ext_enable_i))
        else $error("Wake while enable high");
    AST_RUN_FALL: assert property ($fell(charge_running_o) && pmu_on_i && $past(pmu_on_i)
        |=> irq_pending_flag_o) else $error("Running fall gave no interrupt");
    cover property ($rose(wake_o));
    cover property ($rose(charge_done_o));
    cover property (irq_pending_flag_o && irq_wr_i && irq_wdata_i);
endmodule // chrg_swk_chk

bind chrg_status_irq_wake chrg_swk_chk #(.TERM_CYC(TERM_CYC), .WAKE_CYC(WAKE_CYC)) chk_u (.*);

/* dv/chrg_host_model.sv */
// Host model that clears the pending interrupt through the write strobe
`timescale 1ns/1ps
module chrg_host_model (
    // Clock, reset and bench control
    input  wire       mclk_i,
    input  wire       rstn_i,
    input  wire       en_i,
    input  wire [3:0] dly_i,
    input  wire       wval_i,
    // Interrupt wire and write port
    input  wire       irq_n_i,
    output reg        irq_wr_o,
    output reg        irq_wdata_o
);
    reg [3:0] wait_r;  // Cycles the line has been seen low
    // Wait the set delay on a low line, then write one pulse
    always @(posedge mclk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            wait_r      <= 4'h0;
            irq_wr_o    <= 1'b0;
            irq_wdata_o <= 1'b1;
        end else begin
            irq_wr_o    <= 1'b0;
            irq_wdata_o <= ~irq_wdata_o;  // Data means nothing without the strobe
            if (en_i && !irq_n_i && !irq_wr_o) begin
                wait_r <= wait_r + 4'h1;
                if (wait_r >= dly_i) begin
                    wait_r      <= 4'h0;
                    irq_wr_o    <= 1'b1;
                    irq_wdata_o <= wval_i;
                end
            end else if (irq_n_i) begin
                wait_r <= 4'h0;
            end
        end
    end
endmodule // chrg_host_model

/* dv/chrg_status_irq_wake_tb.sv */
// Self-checking bench of the charger status, interrupt and wake block
`timescale 1ns/1ps
module chrg_status_irq_wake_tb;
    localparam TERM = 8, RECHG = 12, PLUG = 6, WAKE = 10;
    localparam W = 12'h080, P = 12'h040, D = 12'h020, E = 12'h010;
    localparam R = 12'h008, K = 12'h004, B = 12'h002, I = 12'h001;
    reg        mclk_i = 1'b0;
    reg        rstn_i = 1'b0;
    reg        pmu_on_i, suspend_request_i, droop_irq_mask_i, ext_enable_i, plug_bat_i;
    reg        plug_vin_i, vbat_below_2v8_i, vbat_above_3v_i, cv_near_4v2_i, ichg_below_term_i;
    reg        vbat_below_4v1_i, vin_above_uvlo_i, vin_above_bat_osl_i, vin_above_bat_osh_i;
    reg        vin_above_ovp_i, ts_above_90pct_i, thermal_regulation_flag_i;
    reg        safety_timer_flag_i, input_droop_flag_i, hen, hval;
    reg  [3:0] fast_current_code_i, hdly;
    reg  [2:0] thermistor_zone_i;
    wire       irq_wr_i, irq_wdata_i, charge_enable_o, precharge_o, input_power_ok_o;
    wire       battery_absent_o, charge_done_o, charge_running_o, irq_pending_flag_o;
    wire       irq_line_o, irq_line_oe_o, charge_indicator_pin_o, charge_indicator_pin_oe_o;
    wire       wake_o;
    wire [3:0] charge_code_o;
    wire       irq_n = irq_line_oe_o ? irq_line_o : 1'b1;  // Pull-up on the open drain
    integer    miscompares = 0, checks = 0, j, k;
    reg [31:0] seed = 32'd2964;
    reg [23:0] q[$];  // Expected notes: mask then value
    reg [23:0] n;
    event      smp;
    chrg_status_irq_wake #(.TERM_CYC(TERM), .RECHG_CYC(RECHG), .PLUG_CYC(PLUG),
        .WAKE_CYC(WAKE)) dut_u (.*);
    chrg_host_model host_u (.mclk_i(mclk_i), .rstn_i(rstn_i), .en_i(hen), .dly_i(hdly),
        .wval_i(hval), .irq_n_i(irq_n), .irq_wr_o(irq_wr_i), .irq_wdata_o(irq_wdata_i));
    always #20 mclk_i = ~mclk_i;
    function [3:0] rnd(input integer unused);
        begin
            seed = seed ^ (seed << 13);
            seed = seed ^ (seed >> 17);
            seed = seed ^ (seed << 5);
            rnd  = seed[3:0];
        end
    endfunction
    task cyc(input integer c);
        repeat (c) @(posedge mclk_i);
    endtask
    // Note an expectation at the settled half of the cycle
    task chk(input [11:0] m, input [11:0] e);
        begin
            @(negedge mclk_i);
            q.push_back({m, e});
            -> smp;
            @(posedge mclk_i);
        end
    endtask
    // Let the host clear the pending bit, bounded wait
    task hclr;
        begin
            hdly <= rnd(0) & 4'h7;
            hen  <= 1'b1;
            @(negedge mclk_i);
            for (k = 0; k < 40 && irq_pending_flag_o !== 1'b0; k = k + 1) @(negedge mclk_i);
            @(posedge mclk_i);
            hen  <= 1'b0;
        end
    endtask
    task stop_test;
        begin
            $display("Counts: checks %0d miscompares %0d", checks, miscompares);
            if (miscompares == 0 && checks > 0) $display("All checks passed");
            else $display("Checks failed");
            $finish;
        end
    endtask
    // Watcher: compare the oldest note with the outputs
    always @(smp) begin
        n = q.pop_front();
        checks = checks + 1;
        if (({charge_code_o, wake_o, irq_pending_flag_o, charge_done_o, charge_enable_o,
              precharge_o, input_power_ok_o, battery_absent_o, charge_indicator_pin_oe_o}
             & n[23:12]) !== n[11:0]) begin
            miscompares = miscompares + 1;
            $display("Error at %0t: got %h expected %h", $time, {charge_code_o, wake_o,
                irq_pending_flag_o, charge_done_o, charge_enable_o, precharge_o,
                input_power_ok_o, battery_absent_o, charge_indicator_pin_oe_o} & n[23:12],
                n[11:0]);
        end
    end
    initial begin
        {pmu_on_i, suspend_request_i, droop_irq_mask_i, ext_enable_i, plug_bat_i, plug_vin_i,
         vbat_below_2v8_i, vbat_above_3v_i, cv_near_4v2_i, ichg_below_term_i, vbat_below_4v1_i,
         vin_above_uvlo_i, vin_above_bat_osl_i, vin_above_bat_osh_i, vin_above_ovp_i,
         ts_above_90pct_i, thermal_regulation_flag_i, safety_timer_flag_i, input_droop_flag_i,
         hen, hval, fast_current_code_i, thermistor_zone_i, hdly} = 32'h00000012;
        cyc(8);
        rstn_i <= 1'b1;
        cyc(1);
        pmu_on_i <= 1'b1;
        cyc(3);
        chk(P, 12'h000);
        for (j = 0; j < 10; j = j + 1) begin
            case (j % 5)
                0: thermal_regulation_flag_i <= ~thermal_regulation_flag_i;
                1: safety_timer_flag_i <= ~safety_timer_flag_i;
                2: input_droop_flag_i <= ~input_droop_flag_i;
                3: thermistor_zone_i <= thermistor_zone_i ^ 3'h1;
                default: ts_above_90pct_i <= ~ts_above_90pct_i;
            endcase
            cyc(3);
            chk(P | B, P | {10'h000, ts_above_90pct_i, 1'b0});
            hclr;
            chk(P, 12'h000);
        end
        droop_irq_mask_i <= 1'b1;
        cyc(1);
        input_droop_flag_i <= 1'b1;
        cyc(3);
        chk(P, 12'h000);
        thermal_regulation_flag_i <= 1'b1;
        hval <= 1'b1;
        hen <= 1'b1;
        cyc(10);
        chk(P, P);
        hval <= 1'b0;
        hclr;
        pmu_on_i <= 1'b0;
        cyc(2);
        pmu_on_i <= 1'b1;
        cyc(3);
        chk(P, P);
        pmu_on_i <= 1'b0;
        thermal_regulation_flag_i <= 1'b0;
        cyc(2);
        pmu_on_i <= 1'b1;
        cyc(3);
        chk(P, 12'h000);
        $display("Test interrupt events finished");
        {vin_above_uvlo_i, vin_above_bat_osl_i, vin_above_bat_osh_i} <= 3'h7;
        vbat_below_2v8_i <= 1'b1;
        fast_current_code_i <= rnd(0);
        cyc(5);
        chk(12'hF00 | E | R | K | I, {fast_current_code_i, 8'h00} | E | R | K | I);
        {vbat_below_2v8_i, vbat_above_3v_i} <= 2'h1;
        cyc(4);
        chk(E | R, E);
        {cv_near_4v2_i, ichg_below_term_i} <= 2'h3;
        cyc(TERM - 2);
        ichg_below_term_i <= 1'b0;
        cyc(1);
        ichg_below_term_i <= 1'b1;
        cyc(TERM - 2);
        chk(D | E, E);
        cyc(3);
        chk(D | E | I, D);
        {cv_near_4v2_i, ichg_below_term_i, vbat_below_4v1_i} <= 3'h1;
        cyc(RECHG - 3);
        chk(E, 12'h000);
        cyc(4);
        chk(D | E | I, D | E);
        suspend_request_i <= 1'b1;
        cyc(3);
        chk(E | I, 12'h000);
        hclr;
        $display("Test charge phases finished");
        plug_vin_i <= 1'b1;
        cyc(PLUG + 2);
        chk(W, W);
        ext_enable_i <= 1'b1;
        cyc(WAKE - 4);
        chk(W, W);
        plug_vin_i <= 1'b0;
        cyc(2);
        plug_vin_i <= 1'b1;
        cyc(PLUG + 3);
        chk(W, 12'h000);
        {ext_enable_i, plug_vin_i, plug_bat_i} <= 3'h0;
        cyc(2);
        plug_bat_i <= 1'b1;
        cyc(PLUG + 2);
        chk(W, W);
        cyc(WAKE + 2);
        $display("Test wake pulse finished");
        stop_test;
    end
    // Watchdog against a hung run
    initial begin
        #(40 * 3000);
        miscompares = miscompares + 1;
        stop_test;
    end
endmodule // chrg_status_irq_wake_tb
